// ===== src/csw_regs.svh
// Register map, field positions, reset values and sizes of the channel and sync-word block
`ifndef CSW_REGS_SVH
`define CSW_REGS_SVH

// ----------------------------------------------------------------
// Device register offsets
// ----------------------------------------------------------------
`define CSW_ADDR_W            12
`define CSW_OFF_CTRL          12'h200
`define CSW_OFF_STATUS        12'h201
`define CSW_OFF_CHAN          12'h209
`define CSW_OFF_SYNC          12'h20F
`define CSW_OFF_THRESH        12'h210

// ----------------------------------------------------------------
// Device reset values
// ----------------------------------------------------------------
`define CSW_RST_CTRL          8'h04
`define CSW_RST_CHAN          8'h03
`define CSW_RST_SYNC          8'h00
`define CSW_RST_THRESH        8'h03

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CSW_CHAN_LOWER        0
`define CSW_CHAN_UPPER        1
`define CSW_CHAN_SINGLE       2
`define CSW_CHAN_MASK         8'h07
`define CSW_CTRL_LINK         0
`define CSW_CTRL_CAL          1
`define CSW_CTRL_FMT          2
`define CSW_CTRL_MASK         8'h07
`define CSW_CTRL_STOP_MASK    8'hFC
`define CSW_SYNC_MASK         8'h03
`define CSW_SYNC_CRC          2'h0
`define CSW_SYNC_FEC          2'h2
`define CSW_CRC_POLY          12'h80F

// ----------------------------------------------------------------
// Sample and frame sizes
// ----------------------------------------------------------------
`define CSW_SAMPLE_W          12
`define CSW_CHANNELS          4
`define CSW_FRAME_W           48
`define CSW_SYNC_W            32
`define CSW_FULL_LANES        8
`define CSW_FULL_CONV         4
`define CSW_FIFO_DEPTH        32

// ----------------------------------------------------------------
// Controller register offsets
// ----------------------------------------------------------------
`define CSW_SW_ADDR_W         4
`define CSW_SW_CFG_CHAN       4'h0
`define CSW_SW_CFG_SYNC       4'h1
`define CSW_SW_CFG_CTRL       4'h2
`define CSW_SW_CMD            4'h3
`define CSW_SW_STATUS         4'h4
`define CSW_SW_READBACK       4'h5
`define CSW_SW_CMD_APPLY      0
`define CSW_SW_ST_BUSY        0
`define CSW_SW_ST_REFUSED     1

`endif

// ===== src/csw_pkg.sv
// Types shared by both ends of the channel and sync-word link
`default_nettype none
`include "csw_regs.svh"

package csw_pkg;
   typedef logic [`CSW_ADDR_W-1:0]    csw_addr_t;
   typedef logic [7:0]                csw_byte_t;
   typedef logic [`CSW_FRAME_W-1:0]   csw_frame_t;
   typedef logic [`CSW_SYNC_W-1:0]    csw_sync_t;
   typedef logic [`CSW_SW_ADDR_W-1:0] csw_sw_addr_t;

   typedef enum logic [2:0] {
      CSW_H_IDLE,
      CSW_H_CHAN,
      CSW_H_SYNC,
      CSW_H_START,
      CSW_H_READ,
      CSW_H_WAIT,
      CSW_H_CATCH
   } csw_host_state_t;
endpackage : csw_pkg

`default_nettype wire

// ===== src/csw_link_if.sv
// Carrier between the converter end and the link receiver end
`default_nettype none

interface csw_link_if;
   import csw_pkg::*;

   csw_addr_t  regAddr;
   csw_byte_t  regWdata;
   logic       regWrite;
   logic       regRead;
   csw_byte_t  regRdata;
   logic       frameValid;
   logic       frameReady;
   csw_frame_t frameData;
   csw_sync_t  frameSync;
   logic [3:0] laneCount;
   logic [2:0] convCount;
   logic       tailPad;

   modport dev (
      input  regAddr, regWdata, regWrite, regRead, frameReady,
      output regRdata, frameValid, frameData, frameSync, laneCount, convCount, tailPad
   );
   modport host (
      output regAddr, regWdata, regWrite, regRead, frameReady,
      input  regRdata, frameValid, frameData, frameSync, laneCount, convCount, tailPad
   );
endinterface : csw_link_if

`default_nettype wire

// ===== src/csw_device.sv
// Converter end: channel-pair configuration and frame builder
`default_nettype none
`include "csw_regs.svh"

// ----------------------------------------------------------------
// Converter end
// ----------------------------------------------------------------
module csw_device #(
   parameter int FULL_LANES = `CSW_FULL_LANES,
   parameter int FULL_CONV  = `CSW_FULL_CONV,
   parameter int FIFO_DEPTH = `CSW_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                ref_clk,
   input  wire logic                reset_n,
   // Sample input, four channels, A in the low bits
   input  wire logic                sampleValid,
   output logic                     sampleReady,
   input  wire csw_pkg::csw_frame_t sampleData,
   // Link side
   csw_link_if.dev                  link
);
   import csw_pkg::*;

   csw_byte_t  ctrlReg;
   csw_byte_t  chanReg;
   csw_byte_t  syncReg;
   csw_byte_t  threshReg;
   csw_byte_t  rdData;
   csw_byte_t  next_ctrlReg;
   csw_byte_t  next_chanReg;
   csw_byte_t  next_syncReg;
   csw_byte_t  next_threshReg;
   csw_byte_t  next_rdData;
   logic       fifoValid;
   logic       fifoPop;
   csw_frame_t fifoData;
   logic       outValid;
   csw_frame_t outData;
   csw_sync_t  outSync;
   logic       next_outValid;
   csw_frame_t next_outData;
   csw_sync_t  next_outSync;
   logic [3:0] chanMask;
   logic       pairOff;
   logic [3:0] lanes;
   logic [2:0] convs;

   // Active channel mask {D,C,B,A} from the channel-pair register
   function automatic logic [3:0] activeMask(input csw_byte_t c);
      logic [3:0] m;
      m = '0;
      if (c[`CSW_CHAN_SINGLE]) begin
         m = 4'h1;
      end else begin
         m[3:2] = {2{c[`CSW_CHAN_UPPER]}};
         m[1:0] = {2{c[`CSW_CHAN_LOWER]}};
      end
      return m;
   endfunction : activeMask

   // Compacts active channels into the lowest frame slots
   function automatic csw_frame_t packFrame(input csw_frame_t s, input logic [3:0] m);
      csw_frame_t r;
      int         k;
      r = '0;
      k = 0;
      for (int i = 0; i < `CSW_CHANNELS; i++) begin
         if (m[i]) begin
            r[k*`CSW_SAMPLE_W +: `CSW_SAMPLE_W] = s[i*`CSW_SAMPLE_W +: `CSW_SAMPLE_W];
            k++;
         end
      end
      return r;
   endfunction : packFrame

   function automatic logic [11:0] crc12(input csw_frame_t d);
      logic [11:0] c;
      c = '0;
      for (int i = `CSW_FRAME_W - 1; i >= 0; i--) begin
         c = {c[10:0], 1'b0} ^ ((c[11] ^ d[i]) ? `CSW_CRC_POLY : 12'h000);
      end
      return c;
   endfunction : crc12

   // Folded parity; a stand-in for the full FEC code
   function automatic logic [25:0] fecParity(input csw_frame_t d);
      logic [25:0] p;
      p = d[25:0] ^ {4'h0, d[47:26]};
      return p;
   endfunction : fecParity

   // ----------------------------------------------------------------
   // Link configuration
   // ----------------------------------------------------------------
   assign chanMask = activeMask(chanReg);
   assign pairOff  = (chanMask != 4'hF);

   always_comb begin
      lanes = pairOff ? 4'((FULL_LANES + 1) / 2) : 4'(FULL_LANES);
      if (chanReg[`CSW_CHAN_SINGLE]) begin
         convs = 3'h1;
      end else if (pairOff) begin
         convs = 3'(FULL_CONV / 2);
      end else begin
         convs = 3'(FULL_CONV);
      end
   end

   assign link.laneCount = lanes;
   assign link.convCount = convs;
   // tail pad when a pair is off and the full lane count is odd
   assign link.tailPad   = pairOff && (FULL_LANES % 2 == 1);

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   always_comb begin
      next_ctrlReg   = ctrlReg;
      next_chanReg   = chanReg;
      next_syncReg   = syncReg;
      next_threshReg = threshReg;
      next_rdData    = '0;
      // every byte stored whole and read back
      if (link.regWrite) begin
         if (link.regAddr == `CSW_OFF_CTRL) begin
            next_ctrlReg = link.regWdata;
         end else if (link.regAddr == `CSW_OFF_CHAN) begin
            next_chanReg = link.regWdata;
         end else if (link.regAddr == `CSW_OFF_SYNC) begin
            next_syncReg = link.regWdata;
         end else if (link.regAddr == `CSW_OFF_THRESH) begin
            next_threshReg = link.regWdata;
         end
      end
      if (link.regRead) begin
         if (link.regAddr == `CSW_OFF_CTRL) begin
            next_rdData = ctrlReg;
         end else if (link.regAddr == `CSW_OFF_STATUS) begin
            next_rdData = {link.tailPad, convs, lanes};
         end else if (link.regAddr == `CSW_OFF_CHAN) begin
            next_rdData = chanReg;
         end else if (link.regAddr == `CSW_OFF_SYNC) begin
            next_rdData = syncReg;
         end else if (link.regAddr == `CSW_OFF_THRESH) begin
            next_rdData = threshReg;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrlReg   <= `CSW_RST_CTRL;
         chanReg   <= `CSW_RST_CHAN;
         syncReg   <= `CSW_RST_SYNC;
         threshReg <= `CSW_RST_THRESH;
         rdData    <= '0;
      end else begin
         ctrlReg   <= next_ctrlReg;
         chanReg   <= next_chanReg;
         syncReg   <= next_syncReg;
         threshReg <= next_threshReg;
         rdData    <= next_rdData;
      end
   end

   assign link.regRdata = rdData;

   // ----------------------------------------------------------------
   // Sample path
   // ----------------------------------------------------------------
   csw_fifo #(
      .WIDTH (`CSW_FRAME_W),
      .DEPTH (FIFO_DEPTH)
   ) csw_fifo_inst (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .inValid  (sampleValid),
      .inReady  (sampleReady),
      .inData   (sampleData),
      .outValid (fifoValid),
      .outReady (fifoPop),
      .outData  (fifoData)
   );

   // Link off holds samples back; the FIFO then fills and stalls the source
   assign fifoPop = ctrlReg[`CSW_CTRL_LINK] && (!outValid || link.frameReady);

   always_comb begin
      next_outValid = outValid;
      next_outData  = outData;
      next_outSync  = outSync;
      if (link.frameReady) begin
         next_outValid = 1'b0;
      end
      if (fifoPop && fifoValid) begin
         next_outValid = 1'b1;
         // C,D move into A,B slots when lower pair off
         next_outData  = packFrame(fifoData, chanMask);
         next_outSync  = '0;
         // sync word only in 64b/66b format
         if (ctrlReg[`CSW_CTRL_FMT]) begin
            // code picks CRC-12 or FEC, reserved sends zero
            if (syncReg[1:0] == `CSW_SYNC_CRC) begin
               next_outSync = {crc12(packFrame(fifoData, chanMask)), 20'h00000};
            end else if (syncReg[1:0] == `CSW_SYNC_FEC) begin
               next_outSync = {fecParity(packFrame(fifoData, chanMask)), 6'h00};
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         outValid <= 1'b0;
         outData  <= '0;
         outSync  <= '0;
      end else begin
         outValid <= next_outValid;
         outData  <= next_outData;
         outSync  <= next_outSync;
      end
   end

   assign link.frameValid = outValid;
   assign link.frameData  = outData;
   assign link.frameSync  = outSync;
endmodule : csw_device

`default_nettype wire

// ===== src/csw_host.sv
// Link receiver end and the sample FIFO of the converter end
//
// Added by the designer: the strobed register port.
`default_nettype none
`include "csw_regs.svh"

module csw_host (
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  reset_n,
   // Software port
   input  wire csw_pkg::csw_sw_addr_t swAddr,
   input  wire csw_pkg::csw_byte_t    swWdata,
   input  wire logic                  swWrite,
   input  wire logic                  swRead,
   output csw_pkg::csw_byte_t         swRdata,
   // Received frames
   output logic                       userValid,
   input  wire logic                  userReady,
   output csw_pkg::csw_frame_t        userData,
   output csw_pkg::csw_sync_t         userSync,
   // Link side
   csw_link_if.host                   link
);
   import csw_pkg::*;

   csw_host_state_t state;
   csw_host_state_t next_state;
   csw_byte_t       cfgChan;
   csw_byte_t       cfgSync;
   csw_byte_t       cfgCtrl;
   csw_byte_t       readback;
   logic            refused;
   csw_byte_t       rdData;
   csw_addr_t       busAddr;
   csw_byte_t       busWdata;
   logic            busWrite;
   logic            busRead;
   csw_byte_t       next_cfgChan;
   csw_byte_t       next_cfgSync;
   csw_byte_t       next_cfgCtrl;
   csw_byte_t       next_readback;
   logic            next_refused;
   csw_byte_t       next_rdData;
   csw_addr_t       next_busAddr;
   csw_byte_t       next_busWdata;
   logic            next_busWrite;
   logic            next_busRead;
   logic            apply;
   logic            badCfg;
   csw_byte_t       chanOut;
   logic            outValid;
   csw_frame_t      outData;
   csw_sync_t       outSync;

   assign apply  = swWrite && (swAddr == `CSW_SW_CMD) && swWdata[`CSW_SW_CMD_APPLY];
   // Both pairs off is undefined on the device and is refused here
   assign badCfg = !cfgChan[`CSW_CHAN_SINGLE] && !cfgChan[`CSW_CHAN_UPPER]
                   && !cfgChan[`CSW_CHAN_LOWER];

   always_comb begin
      // Reserved bits cleared, lower pair forced in single mode
      chanOut = cfgChan & `CSW_CHAN_MASK;
      if (cfgChan[`CSW_CHAN_SINGLE]) begin
         chanOut[`CSW_CHAN_LOWER] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Sequencer and software registers
   // ----------------------------------------------------------------
   always_comb begin
      next_state    = state;
      next_cfgChan  = cfgChan;
      next_cfgSync  = cfgSync;
      next_cfgCtrl  = cfgCtrl;
      next_readback = readback;
      next_refused  = refused;
      next_rdData   = '0;
      next_busAddr  = busAddr;
      next_busWdata = busWdata;
      next_busWrite = 1'b0;
      next_busRead  = 1'b0;
      if (swWrite && state == CSW_H_IDLE) begin
         if (swAddr == `CSW_SW_CFG_CHAN) begin
            next_cfgChan = swWdata;
         end else if (swAddr == `CSW_SW_CFG_SYNC) begin
            next_cfgSync = swWdata;
         end else if (swAddr == `CSW_SW_CFG_CTRL) begin
            next_cfgCtrl = swWdata;
         end
      end
      if (swRead) begin
         if (swAddr == `CSW_SW_CFG_CHAN) begin
            next_rdData = cfgChan;
         end else if (swAddr == `CSW_SW_CFG_SYNC) begin
            next_rdData = cfgSync;
         end else if (swAddr == `CSW_SW_CFG_CTRL) begin
            next_rdData = cfgCtrl;
         end else if (swAddr == `CSW_SW_STATUS) begin
            next_rdData = {6'h00, refused, state != CSW_H_IDLE};
         end else if (swAddr == `CSW_SW_READBACK) begin
            next_rdData = readback;
         end
      end
      case (state)
         CSW_H_IDLE: begin
            if (apply) begin
               next_refused = badCfg;
               if (!badCfg) begin
                  next_busWrite = 1'b1;
                  next_busAddr  = `CSW_OFF_CTRL;
                  next_busWdata = cfgCtrl & `CSW_CTRL_MASK & `CSW_CTRL_STOP_MASK;
                  next_state    = CSW_H_CHAN;
               end
            end
         end
         CSW_H_CHAN: begin
            // lower pair held on in single mode
            next_busWrite = 1'b1;
            next_busAddr  = `CSW_OFF_CHAN;
            next_busWdata = chanOut;
            next_state    = CSW_H_SYNC;
         end
         CSW_H_SYNC: begin
            // written while link is still off
            next_busWrite = 1'b1;
            next_busAddr  = `CSW_OFF_SYNC;
            next_busWdata = cfgSync & `CSW_SYNC_MASK;
            next_state    = CSW_H_START;
         end
         CSW_H_START: begin
            next_busWrite = 1'b1;
            next_busAddr  = `CSW_OFF_CTRL;
            next_busWdata = cfgCtrl & `CSW_CTRL_MASK;
            next_state    = CSW_H_READ;
         end
         CSW_H_READ: begin
            next_busRead = 1'b1;
            next_busAddr = `CSW_OFF_CHAN;
            next_state   = CSW_H_WAIT;
         end
         CSW_H_WAIT: begin
            next_state = CSW_H_CATCH;
         end
         CSW_H_CATCH: begin
            next_readback = link.regRdata;
            next_state    = CSW_H_IDLE;
         end
         default: begin
            next_state = CSW_H_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state    <= CSW_H_IDLE;
         cfgChan  <= `CSW_RST_CHAN;
         cfgSync  <= `CSW_RST_SYNC;
         cfgCtrl  <= `CSW_RST_CTRL;
         readback <= '0;
         refused  <= 1'b0;
         rdData   <= '0;
         busAddr  <= '0;
         busWdata <= '0;
         busWrite <= 1'b0;
         busRead  <= 1'b0;
      end else begin
         state    <= next_state;
         cfgChan  <= next_cfgChan;
         cfgSync  <= next_cfgSync;
         cfgCtrl  <= next_cfgCtrl;
         readback <= next_readback;
         refused  <= next_refused;
         rdData   <= next_rdData;
         busAddr  <= next_busAddr;
         busWdata <= next_busWdata;
         busWrite <= next_busWrite;
         busRead  <= next_busRead;
      end
   end

   assign swRdata       = rdData;
   assign link.regAddr  = busAddr;
   assign link.regWdata = busWdata;
   assign link.regWrite = busWrite;
   assign link.regRead  = busRead;

   // ----------------------------------------------------------------
   // Frame sink, one register stage toward the user
   // ----------------------------------------------------------------
   assign link.frameReady = !outValid || userReady;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         outValid <= 1'b0;
         outData  <= '0;
         outSync  <= '0;
      end else if (link.frameReady) begin
         outValid <= link.frameValid;
         outData  <= link.frameValid ? link.frameData : outData;
         outSync  <= link.frameValid ? link.frameSync : outSync;
      end
   end

   assign userValid = outValid;
   assign userData  = outData;
   assign userSync  = outSync;
endmodule : csw_host

// ----------------------------------------------------------------
// Sample FIFO
// ----------------------------------------------------------------
module csw_fifo #(
   parameter int WIDTH = `CSW_FRAME_W,
   parameter int DEPTH = `CSW_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   // Fill side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr;
   logic [AW-1:0]    rdPtr;
   logic [AW:0]      fill;
   logic [AW-1:0]    next_wrPtr;
   logic [AW-1:0]    next_rdPtr;
   logic [AW:0]      next_fill;
   logic             doPush;
   logic             doPop;

   assign inReady  = (fill != (AW+1)'(DEPTH));
   assign outValid = (fill != '0);
   assign outData  = mem[rdPtr];
   assign doPush   = inValid && inReady;
   assign doPop    = outValid && outReady;

   always_comb begin
      next_wrPtr = doPush ? ((wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1) : wrPtr;
      next_rdPtr = doPop ? ((rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1) : rdPtr;
      next_fill  = fill + (AW+1)'(doPush) - (AW+1)'(doPop);
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
         fill  <= '0;
      end else begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         fill  <= next_fill;
      end
   end

   // Storage has no reset on purpose: contents are gated by fill
   always_ff @(posedge ref_clk) begin
      if (doPush) begin
         mem[wrPtr] <= inData;
      end
   end
endmodule : csw_fifo

`default_nettype wire

// ===== test/csw_properties.sv
// Checker on the link between the converter end and the receiver end
`default_nettype none
module csw_properties (
   // Clock and reset
   input wire logic               ref_clk,
   input wire logic               reset_n,
   // Register bus
   input wire csw_pkg::csw_addr_t regAddr,
   input wire csw_pkg::csw_byte_t regWdata,
   input wire logic               regWrite,
   input wire logic               regRead,
   input wire csw_pkg::csw_byte_t regRdata,
   // Frames and counts
   input wire logic               frameValid,
   input wire logic               frameReady,
   input wire csw_pkg::csw_sync_t frameSync,
   input wire logic [3:0]         laneCount,
   input wire logic [2:0]         convCount,
   input wire logic               tailPad
);
   import csw_pkg::*;
   // Shadow of the channel register, mirrors reset value
   csw_byte_t chan;
   logic      full;
   always_ff @(posedge ref_clk or negedge reset_n)
      if (!reset_n) chan <= 8'h03;
      else if (regWrite && regAddr == 12'h209) chan <= regWdata;
   assign full = chan[2:0] == 3'h3;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_lane_count: assert property (laneCount == (full ? 4'h8 : 4'h4))
      else $error("lane count wrong");
   a_conv_count: assert property (convCount == (chan[2] ? 3'h1 : full ? 3'h4 : 3'h2))
      else $error("converter count wrong");
   a_tail_off: assert property (tailPad == 1'b0)
      else $error("tail pad with even lanes");
   a_chan_read: assert property (regRead && regAddr == 12'h209 |=> regRdata == chan)
      else $error("channel readback wrong");
   a_rd_idle: assert property (!regRead |=> regRdata == 8'h00)
      else $error("read data outside slot");
   a_frame_hold: assert property (frameValid && !frameReady |=> frameValid && $stable(frameSync))
      else $error("frame dropped while stalled");
   a_cmd_zero: assert property (frameValid |-> frameSync[5:0] == 6'h00)
      else $error("command bits set");
   a_lane_cause: assert property ($changed(laneCount) |-> $past(regWrite))
      else $error("lane count moved without write");
   a_one_strobe: assert property (!(regWrite && regRead))
      else $error("both strobes high");
   cover property (frameValid && frameReady);
   cover property (convCount == 3'h1);
   cover property (regRead && regAddr == 12'h209);
endmodule : csw_properties
`default_nettype wire

// ===== test/channel_enable_sync_word_config_tb.sv
// Bench joining both ends of the channel and sync-word link
`default_nettype none
module channel_enable_sync_word_config_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import csw_pkg::*;
   logic ref_clk = 1'b0, reset_n = 1'b0, sampleValid = 1'b0, userReady = 1'b1;
   logic swWrite = 1'b0, swRead = 1'b0, sampleReady, userValid;
   csw_frame_t sampleData = 48'hDDDCCCBBBAAA, userData;
   csw_sw_addr_t swAddr = 4'h0;
   csw_byte_t swWdata = 8'h00, swRdata, v;
   csw_sync_t userSync;
   int n_mismatch = 0, cmp_count = 0, cyc = 0, n;
   csw_link_if lnk ();
   csw_device csw_device_inst (.ref_clk, .reset_n, .sampleValid, .sampleReady, .sampleData,
      .link(lnk));
   csw_host csw_host_inst (.ref_clk, .reset_n, .swAddr, .swWdata, .swWrite, .swRead, .swRdata,
      .userValid, .userReady, .userData, .userSync, .link(lnk));
   csw_properties csw_properties_inst (.ref_clk, .reset_n, .regAddr(lnk.regAddr),
      .regWdata(lnk.regWdata), .regWrite(lnk.regWrite), .regRead(lnk.regRead),
      .regRdata(lnk.regRdata), .frameValid(lnk.frameValid), .frameReady(lnk.frameReady),
      .frameSync(lnk.frameSync), .laneCount(lnk.laneCount), .convCount(lnk.convCount),
      .tailPad(lnk.tailPad));
   initial forever #12.5 ref_clk = ~ref_clk;
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   // Hang guard, run needs about 500 cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input csw_sw_addr_t a, input csw_byte_t d);
      @(posedge ref_clk);
      swAddr <= a;
      swWdata <= d;
      swWrite <= 1'b1;
      @(posedge ref_clk);
      swWrite <= 1'b0;
   endtask : wr
   task automatic rd(input csw_sw_addr_t a);
      @(posedge ref_clk);
      swAddr <= a;
      swRead <= 1'b1;
      @(posedge ref_clk);
      swRead <= 1'b0;
      #1 v = swRdata;
   endtask : rd
   // Reference CRC-12, poly 0x80F, msb first, zero start
   function automatic csw_sync_t crc_ref(input csw_frame_t d);
      logic [11:0] c;
      c = 12'h000;
      for (int i = 47; i >= 0; i--) c = {c[10:0], 1'b0} ^ ((c[11] ^ d[i]) ? 12'h80F : 12'h000);
      return {c, 20'h00000};
   endfunction : crc_ref
   // Program config, start apply, poll busy with a bound
   task automatic apply(input csw_byte_t c, input csw_byte_t s, input csw_byte_t k);
      wr(4'h0, c);
      wr(4'h1, s);
      wr(4'h2, k);
      wr(4'h3, 8'h01);
      for (int i = 0; i < 20; i++) begin
         rd(4'h4);
         if (v[0] === 1'b0) break;
      end
      chk(v[0], 1'b0);
   endtask : apply
   task automatic t_reset();
      rd(4'h0);
      chk(v, 8'h03);
      chk(lnk.laneCount, 4'h8);
      chk(lnk.convCount, 3'h4);
   endtask : t_reset
   task automatic t_modes();
      csw_byte_t cf[4] = '{8'h03, 8'h01, 8'h02, 8'h05};
      for (int i = 0; i < 4; i++) begin
         apply(cf[i], 8'h00, 8'h05);
         rd(4'h5);
         chk(v, cf[i]);
         chk(lnk.laneCount, cf[i] == 8'h03 ? 4'h8 : 4'h4);
         chk(lnk.convCount, cf[i][2] ? 3'h1 : cf[i] == 8'h03 ? 3'h4 : 3'h2);
      end
      apply(8'h00, 8'h00, 8'h05);
      rd(4'h4);
      chk(v[1], 1'b1);
   endtask : t_modes
   task automatic t_frame(input csw_byte_t c, s, k, input csw_frame_t e, input csw_sync_t y);
      apply(c, s, k);
      @(posedge ref_clk);
      sampleValid <= 1'b1;
      @(posedge ref_clk);
      sampleValid <= 1'b0;
      for (int i = 0; i < 20; i++) begin
         @(posedge ref_clk);
         #1;
         if (userValid === 1'b1) break;
      end
      chk(userValid, 1'b1);
      chk(userData, e);
      chk(userSync, y);
   endtask : t_frame
   // Fill with link off until refused, then drain with a stalling sink
   task automatic t_fifo();
      apply(8'h03, 8'h00, 8'h04);
      n = 0;
      @(posedge ref_clk);
      sampleValid <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(negedge ref_clk);
         if (sampleReady !== 1'b1) break;
         n++;
      end
      @(posedge ref_clk);
      sampleValid <= 1'b0;
      userReady <= 1'b0;
      chk(n, 32);
      apply(8'h03, 8'h00, 8'h05);
      n = 0;
      for (int i = 0; i < 200; i++) begin
         @(negedge ref_clk);
         if (userValid && userReady) n++;
         @(posedge ref_clk);
         userReady <= i[0];
      end
      chk(n, 32);
      userReady <= 1'b1;
   endtask : t_fifo
   initial begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_reset();
      t_modes();
      t_frame(8'h02, 8'h02, 8'h05, 48'h000000DDDCCC, 32'h37773300);
      t_frame(8'h03, 8'h00, 8'h05, 48'hDDDCCCBBBAAA, crc_ref(48'hDDDCCCBBBAAA));
      t_frame(8'h05, 8'h01, 8'h05, 48'h000000000AAA, 32'h0);
      t_frame(8'h01, 8'h03, 8'h05, 48'h000000BBBAAA, 32'h0);
      t_frame(8'h03, 8'h00, 8'h01, 48'hDDDCCCBBBAAA, 32'h0);
      t_fifo();
      end_of_test();
   end
endmodule : channel_enable_sync_word_config_tb
`default_nettype wire
